// [hdl/eivp_pkg.sv]
package eivp_pkg;
   // ***********************
   // Register map (APB byte addresses)
   // ***********************
   localparam logic [7:0] ADDR_CPU_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_SENSE_CTRL = 8'h04;
   localparam logic [7:0] ADDR_GROUP_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_EXT_ENABLE = 8'h0C;
   localparam logic [7:0] ADDR_MASK0 = 8'h10;
   localparam logic [7:0] ADDR_MASK1 = 8'h14;
   localparam logic [7:0] ADDR_MASK2 = 8'h18;
   localparam logic [7:0] ADDR_MASK3 = 8'h1C;
   localparam logic [7:0] ADDR_PENDING = 8'h20;
   localparam logic [7:0] ADDR_PROTECT = 8'h24;
   localparam logic [7:0] ADDR_VECTORS = 8'h28;
   // ***********************
   // Fields and constants
   // ***********************
   localparam int VSEL_BIT = 1;
   localparam logic [7:0] PROTECT_KEY = 8'hD8;
   localparam logic [2:0] PROTECT_WINDOW = 3'h4;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] TABLE_BASE = 16'h0001;
   localparam logic [15:0] BOOT_START_DEFAULT = 16'h0C00;
   localparam int NUM_PC = 28;
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   localparam logic FUSE_PROGRAMMED = 1'b0;

   // Reset and table vector addresses towards the processor
   typedef struct packed {
      logic [15:0] resetAddr;
      logic [15:0] tableAddr;
   } eivp_vec_t;

   // Protection state of the vector select write
   typedef enum logic [1:0] {
      PROT_IDLE = 2'b00,
      PROT_OPEN = 2'b01
   } eivp_prot_t;
endpackage

// [hdl/eivp_ext_detect.sv]
`timescale 1ns/1ps
module eivp_ext_detect
   import eivp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic pin,
   input wire logic ioClkRun,
   input wire logic [1:0] sense,
   output logic edgeHit,
   output logic lowAsync
);
   // ***********************
   // Sampling
   // ***********************
   logic sync1, sync2, prevSample;
   logic next_sync1, next_sync2, next_prevSample;

   // Two-stage sync, then one sample kept for edge compare
   always_comb begin
      next_sync1 = pin;
      next_sync2 = sync1;
      next_prevSample = ioClkRun ? sync2 : prevSample;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         prevSample <= 1'b1;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         prevSample <= next_prevSample;
      end
   end

   // Edges only counted while I/O clock runs; low level bypasses clocks
   always_comb begin
      lowAsync = (sense == SENSE_LOW) && !pin;
      edgeHit = 1'b0;
      if (ioClkRun) begin
         case (sense)
            SENSE_ANY: edgeHit = sync2 != prevSample;
            SENSE_FALL: edgeHit = prevSample && !sync2;
            SENSE_RISE: edgeHit = !prevSample && sync2;
            default: edgeHit = 1'b0;
         endcase
      end
   end
endmodule

// [hdl/eivp_pc_group.sv]
`timescale 1ns/1ps
module eivp_pc_group
   import eivp_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pins,
   input wire logic [WIDTH-1:0] mask,
   input wire logic ioClkRun,
   output logic toggleHit,
   output logic wakeAsync
);
   // ***********************
   // Change detection
   // ***********************
   logic [WIDTH-1:0] sync1, sync2, refLevel;
   logic [WIDTH-1:0] next_sync1, next_sync2, next_refLevel;

   // Reference only advances with the I/O clock so a revert cancels it
   always_comb begin
      next_sync1 = pins;
      next_sync2 = sync1;
      next_refLevel = ioClkRun ? sync2 : refLevel;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync1 <= '0;
         sync2 <= '0;
         refLevel <= '0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         refLevel <= next_refLevel;
      end
   end

   // Request needs the I/O clock; wake path is pure gates on the pins
   always_comb begin
      toggleHit = ioClkRun && |((sync2 ^ refLevel) & mask);
      wakeAsync = |((pins ^ refLevel) & mask);
   end
endmodule

// [hdl/eivp_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - vector select adds boot start to table address
// - programmed boot fuse starts at boot address
// - reset and table address per fuse, select
// - fuse one unprogrammed, zero programmed
// - pins as outputs still trigger interrupts
// - four groups toggle on their pin banks
// - per-pin masks gate group contributions
// - pin change wake detected asynchronously
// - pin change request needs I/O clock
// - reverted pin wakes but no request
// - level mode requests while pin low
// - edge recognition needs running I/O clock
// - low level sensed asynchronously for wake
// - short low wakes without interrupt; the code still raises the request for as long as the pin is low
// - control register other bits read zero
// - vector select lives at bit one
// - sense codes low, any, fall, rise
// - group needs own and global enable
module eivp_top
   import eivp_pkg::*;
#(
   parameter logic [15:0] BOOT_START = BOOT_START_DEFAULT
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_reset_fuse,
   input wire logic globalIrqEnable,
   input wire logic ioClkRun,
   input wire logic [1:0] extPins,
   input wire logic [NUM_PC-1:0] pin_change_input,
   input wire logic [5:0] irqAck,
   output logic [5:0] irqRequest,
   output logic wakeRequest,
   output eivp_vec_t vectors
);
   // ***********************
   // Register state
   // ***********************
   logic vector_select_bit, next_vector_select_bit;
   logic [3:0] senseCtrl, next_senseCtrl;
   logic [3:0] pin_change_group_enable, next_pin_change_group_enable;
   logic [1:0] extEnable, next_extEnable;
   logic [7:0] pin_change_mask0, pin_change_mask1, pin_change_mask2;
   logic [7:0] next_pin_change_mask0, next_pin_change_mask1, next_pin_change_mask2;
   logic [3:0] pin_change_mask3, next_pin_change_mask3;
   eivp_prot_t protState, next_protState;
   logic [2:0] protCount, next_protCount;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [5:0] pending, next_pending;
   logic [5:0] next_irqRequest;
   logic next_wakeRequest;
   logic fuseSeen, next_fuseSeen;
   eivp_vec_t next_vectors;
   logic setup, wrStrobe;

   // Register index check behind pslverr for both reads and writes
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         ADDR_CPU_CONTROL, ADDR_SENSE_CTRL, ADDR_GROUP_ENABLE, ADDR_EXT_ENABLE,
         ADDR_MASK0, ADDR_MASK1, ADDR_MASK2, ADDR_MASK3, ADDR_PENDING,
         ADDR_PROTECT, ADDR_VECTORS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // ***********************
   // Detectors
   // ***********************
   logic [1:0] extEdge, extLow;
   logic [3:0] pcHit, pcWake;

   for (genvar i = 0; i < 2; i++) begin : g_ext
      eivp_ext_detect u_ext (
         .clk_sys(clk_sys),
         .reset(reset),
         .pin(extPins[i]),
         .ioClkRun(ioClkRun),
         .sense(senseCtrl[2*i +: 2]),
         .edgeHit(extEdge[i]),
         .lowAsync(extLow[i])
      );
   end

   eivp_pc_group #(.WIDTH(8)) u_pc0 (
      .clk_sys(clk_sys), .reset(reset), .pins(pin_change_input[7:0]),
      .mask(pin_change_mask0), .ioClkRun(ioClkRun),
      .toggleHit(pcHit[0]), .wakeAsync(pcWake[0])
   );
   eivp_pc_group #(.WIDTH(8)) u_pc1 (
      .clk_sys(clk_sys), .reset(reset), .pins(pin_change_input[15:8]),
      .mask(pin_change_mask1), .ioClkRun(ioClkRun),
      .toggleHit(pcHit[1]), .wakeAsync(pcWake[1])
   );
   eivp_pc_group #(.WIDTH(8)) u_pc2 (
      .clk_sys(clk_sys), .reset(reset), .pins(pin_change_input[23:16]),
      .mask(pin_change_mask2), .ioClkRun(ioClkRun),
      .toggleHit(pcHit[2]), .wakeAsync(pcWake[2])
   );
   eivp_pc_group #(.WIDTH(4)) u_pc3 (
      .clk_sys(clk_sys), .reset(reset), .pins(pin_change_input[27:24]),
      .mask(pin_change_mask3), .ioClkRun(ioClkRun),
      .toggleHit(pcHit[3]), .wakeAsync(pcWake[3])
   );

   // ***********************
   // APB slave, zero wait states
   // ***********************
   assign setup = psel && !penable;
   assign wrStrobe = psel && penable && pwrite && pready;

   // Register writes, key window and read data
   always_comb begin
      next_senseCtrl = senseCtrl;
      next_pin_change_group_enable = pin_change_group_enable;
      next_extEnable = extEnable;
      next_pin_change_mask0 = pin_change_mask0;
      next_pin_change_mask1 = pin_change_mask1;
      next_pin_change_mask2 = pin_change_mask2;
      next_pin_change_mask3 = pin_change_mask3;
      next_vector_select_bit = vector_select_bit;
      next_protState = protState;
      next_protCount = protCount;
      next_pready = setup;
      next_pslverr = setup && !mapped(paddr);
      next_prdata = '0;
      // Key window closes after four cycles, or at once on a control register write
      if (protState == PROT_OPEN) begin
         if (protCount == 3'h1) begin
            next_protState = PROT_IDLE;
         end
         next_protCount = protCount - 3'h1;
      end
      if (wrStrobe) begin
         case (paddr)
            ADDR_CPU_CONTROL: begin
               if (protState == PROT_OPEN) begin
                  next_vector_select_bit = pwdata[VSEL_BIT];
                  next_protState = PROT_IDLE;
               end
            end
            ADDR_SENSE_CTRL: next_senseCtrl = pwdata[3:0];
            ADDR_GROUP_ENABLE: next_pin_change_group_enable = pwdata[3:0];
            ADDR_EXT_ENABLE: next_extEnable = pwdata[1:0];
            ADDR_MASK0: next_pin_change_mask0 = pwdata[7:0];
            ADDR_MASK1: next_pin_change_mask1 = pwdata[7:0];
            ADDR_MASK2: next_pin_change_mask2 = pwdata[7:0];
            ADDR_MASK3: next_pin_change_mask3 = pwdata[3:0];
            ADDR_PROTECT: begin
               if (pwdata[7:0] == PROTECT_KEY) begin
                  next_protState = PROT_OPEN;
                  next_protCount = PROTECT_WINDOW;
               end
            end
            default: ;
         endcase
      end
      if (setup && !pwrite) begin
         case (paddr)
            ADDR_CPU_CONTROL: next_prdata[VSEL_BIT] = vector_select_bit;
            ADDR_SENSE_CTRL: next_prdata[3:0] = senseCtrl;
            ADDR_GROUP_ENABLE: next_prdata[3:0] = pin_change_group_enable;
            ADDR_EXT_ENABLE: next_prdata[1:0] = extEnable;
            ADDR_MASK0: next_prdata[7:0] = pin_change_mask0;
            ADDR_MASK1: next_prdata[7:0] = pin_change_mask1;
            ADDR_MASK2: next_prdata[7:0] = pin_change_mask2;
            ADDR_MASK3: next_prdata[3:0] = pin_change_mask3;
            ADDR_PENDING: next_prdata[5:0] = pending;
            ADDR_PROTECT: next_prdata[0] = protState == PROT_OPEN;
            ADDR_VECTORS: next_prdata = vectors;
            default: next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         senseCtrl <= '0;
         pin_change_group_enable <= '0;
         extEnable <= '0;
         pin_change_mask0 <= '0;
         pin_change_mask1 <= '0;
         pin_change_mask2 <= '0;
         pin_change_mask3 <= '0;
         vector_select_bit <= 1'b0;
         protState <= PROT_IDLE;
         protCount <= '0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         senseCtrl <= next_senseCtrl;
         pin_change_group_enable <= next_pin_change_group_enable;
         extEnable <= next_extEnable;
         pin_change_mask0 <= next_pin_change_mask0;
         pin_change_mask1 <= next_pin_change_mask1;
         pin_change_mask2 <= next_pin_change_mask2;
         pin_change_mask3 <= next_pin_change_mask3;
         vector_select_bit <= next_vector_select_bit;
         protState <= next_protState;
         protCount <= next_protCount;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ***********************
   // Pending, requests, vectors
   // ***********************
   // Hardware set beats the acknowledge in the same cycle
   always_comb begin
      logic [5:0] setEv;
      setEv = {pcHit & pin_change_group_enable, extEdge & extEnable};
      next_pending = (pending & ~irqAck) | setEv;
      // Level mode is not latched: request only while pin is low
      next_irqRequest[1:0] = globalIrqEnable ?
         ((next_pending[1:0] | (extLow & extEnable)) & extEnable) : 2'b00;
      next_irqRequest[5:2] = globalIrqEnable ? next_pending[5:2] : 4'h0;
      // Wake pulses even when the cause later vanishes, style
      next_wakeRequest = |(extLow & extEnable) | |(pcWake & pin_change_group_enable);
      next_fuseSeen = boot_reset_fuse;
      next_vectors.resetAddr = (fuseSeen == FUSE_PROGRAMMED) ? BOOT_START : RESET_VECTOR;
      next_vectors.tableAddr = vector_select_bit ? 16'(BOOT_START + TABLE_BASE) : TABLE_BASE;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pending <= '0;
         irqRequest <= '0;
         wakeRequest <= 1'b0;
         fuseSeen <= 1'b1;
         vectors <= '{resetAddr: RESET_VECTOR, tableAddr: TABLE_BASE};
      end else begin
         pending <= next_pending;
         irqRequest <= next_irqRequest;
         wakeRequest <= next_wakeRequest;
         fuseSeen <= next_fuseSeen;
         vectors <= next_vectors;
      end
   end

   // ***********************
   // Checks
   // ***********************
   a_vsel_table: assert property (@(posedge clk_sys) disable iff (reset)
      vector_select_bit |=> vectors.tableAddr == BOOT_START + TABLE_BASE)
      else $error("table not moved to boot");
   a_fuse_reset: assert property (@(posedge clk_sys) disable iff (reset)
      !fuseSeen |=> vectors.resetAddr == BOOT_START)
      else $error("reset address not boot");
   a_plain_table: assert property (@(posedge clk_sys) disable iff (reset)
      !vector_select_bit && fuseSeen |=> vectors == {RESET_VECTOR, TABLE_BASE})
      else $error("default vectors wrong");
   a_ctrl_zero: assert property (@(posedge clk_sys) disable iff (reset)
      pready && !pwrite && paddr == ADDR_CPU_CONTROL |-> prdata[31:2] == '0 && !prdata[0])
      else $error("reserved control bits set");
   a_key_needed: assert property (@(posedge clk_sys) disable iff (reset)
      protState == PROT_IDLE |=> $stable(vector_select_bit))
      else $error("vector select changed unlocked");
   a_group_gate: assert property (@(posedge clk_sys) disable iff (reset)
      !globalIrqEnable |=> irqRequest[5:2] == 4'h0)
      else $error("group request without global enable");
   a_pend_hold: assert property (@(posedge clk_sys) disable iff (reset)
      pending[2] && !irqAck[2] |=> pending[2])
      else $error("pending lost before ack");
   a_level_req: assert property (@(posedge clk_sys) disable iff (reset)
      globalIrqEnable && extEnable[0] && senseCtrl[1:0] == SENSE_LOW && !extPins[0]
      |=> irqRequest[0])
      else $error("level request missing");
endmodule

// [tb/eivp_far_side.sv]
`timescale 1ns/1ps
// ***********************
// Pins and processor core model
// ***********************
module eivp_far_side
   import eivp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic ackOn,
   input wire logic [5:0] irqRequest,
   output logic [1:0] extPins,
   output logic [NUM_PC-1:0] pinChange,
   output logic [5:0] irqAck
);
   initial begin
      extPins = 2'h3;
      pinChange = '0;
   end
   // Core acknowledges what it sees, only while told to take interrupts
   always @(posedge clk_sys) begin
      irqAck <= ackOn ? irqRequest : 6'h00;
   end
   // Pins hold their level until told otherwise, so wake-up sees it stable
   task automatic setPins(input logic [1:0] e, input logic [NUM_PC-1:0] p);
      @(posedge clk_sys);
      extPins <= e;
      pinChange <= p;
   endtask
endmodule

// [tb/eivp_top_bench.sv]
`timescale 1ns/1ps
module eivp_top_bench
   import eivp_pkg::*;
;
   localparam logic [15:0] BOOT = 16'h0C00;
   logic clk_sys, reset, psel, penable, pwrite, bootFuse, gie, ioClk, ackOn, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic pready, pslverr, wakeRequest;
   logic [5:0] irqRequest, irqAck;
   logic [1:0] extPins;
   logic [NUM_PC-1:0] pcIn, pc;
   eivp_vec_t vectors;
   int err_count, n_compared;
   logic [1:0] code;
   eivp_top #(.BOOT_START(BOOT)) u_eivp_top (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_reset_fuse(bootFuse),
      .globalIrqEnable(gie), .ioClkRun(ioClk), .extPins(extPins),
      .pin_change_input(pcIn), .irqAck(irqAck), .irqRequest(irqRequest),
      .wakeRequest(wakeRequest), .vectors(vectors));
   eivp_far_side u_eivp_far_side (.clk_sys(clk_sys), .ackOn(ackOn),
      .irqRequest(irqRequest), .extPins(extPins), .pinChange(pcIn), .irqAck(irqAck));
   // ***********************
   // Clock and helpers
   // ***********************
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until the edge that samples pready high; data taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic ackPulse();
      @(posedge clk_sys);
      ackOn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ackOn <= 1'b0;
      waitc(2);
   endtask
   task conclude();
      $display("Comparisons %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
   // ***********************
   // Tests
   // ***********************
   initial begin
      err_count = 0; n_compared = 0; pc = '0;
      reset = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
      bootFuse = 1'b1; gie = 1'b1; ioClk = 1'b1; ackOn = 1'b0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      waitc(2);
      chk(vectors, 32'h00000001);
      @(posedge clk_sys) bootFuse <= 1'b0;
      waitc(3);
      chk(vectors.resetAddr, {16'h0, BOOT});
      // Unlocked write must be ignored
      apb(1, ADDR_CPU_CONTROL, 32'h00000002);
      apb(0, ADDR_CPU_CONTROL, 32'h0);
      chk(r, 32'h0);
      apb(1, ADDR_PROTECT, {24'h0, PROTECT_KEY});
      apb(1, ADDR_CPU_CONTROL, 32'h000000FF);
      apb(0, ADDR_CPU_CONTROL, 32'h0);
      chk(r, 32'h00000002);
      chk(vectors, {BOOT, BOOT + 16'h0001});
      apb(0, 8'h3C, 32'h0);
      chk({r[30:0], e}, 32'h1);
      // Pin-change groups, one masked pin and one enabled pin each
      apb(1, ADDR_GROUP_ENABLE, 32'h0000000F);
      for (int g = 0; g < 4; g++) begin
         apb(1, ADDR_MASK0 + 8'(4 * g), 32'h00000002);
         pc[8 * g] = ~pc[8 * g];
         u_eivp_far_side.setPins(2'h3, pc);
         waitc(6);
         chk(irqRequest[5:2], 32'h0);
         pc[8 * g + 1] = ~pc[8 * g + 1];
         u_eivp_far_side.setPins(2'h3, pc);
         waitc(6);
         chk(irqRequest[5:2], 32'(1 << g));
         waitc(10);
         chk(irqRequest[5:2], 32'(1 << g));
         ackPulse();
         chk(irqRequest[5:2], 32'h0);
      end
      @(posedge clk_sys) gie <= 1'b0;
      pc[1] = ~pc[1];
      u_eivp_far_side.setPins(2'h3, pc);
      waitc(6);
      chk(irqRequest[2], 32'h0);
      @(posedge clk_sys) gie <= 1'b1;
      ackPulse();
      // Toggle and revert while the I/O clock is stopped
      @(posedge clk_sys) ioClk <= 1'b0;
      pc[1] = ~pc[1];
      u_eivp_far_side.setPins(2'h3, pc);
      waitc(6);
      chk({irqRequest[2], wakeRequest}, 32'h1);
      pc[1] = ~pc[1];
      u_eivp_far_side.setPins(2'h3, pc);
      waitc(3);
      @(posedge clk_sys) ioClk <= 1'b1;
      waitc(6);
      chk(irqRequest[2], 32'h0);
      // Every sense code on the first dedicated pin
      apb(1, ADDR_EXT_ENABLE, 32'h00000001);
      for (int c = 0; c < 4; c++) begin
         code = 2'(c);
         apb(1, ADDR_SENSE_CTRL, {30'h0, code});
         ackPulse();
         u_eivp_far_side.setPins(2'h2, pc);
         waitc(6);
         chk(irqRequest[0], 32'(code != SENSE_RISE));
         ackPulse();
         chk(irqRequest[0], 32'(code == SENSE_LOW));
         u_eivp_far_side.setPins(2'h3, pc);
         waitc(6);
         chk(irqRequest[0], 32'(code == SENSE_ANY || code == SENSE_RISE));
         ackPulse();
      end
      // Edge needs the I/O clock, low level wakes without it
      apb(1, ADDR_SENSE_CTRL, {30'h0, SENSE_FALL});
      ioClk <= 1'b0;
      u_eivp_far_side.setPins(2'h2, pc);
      waitc(6);
      chk(irqRequest[0], 32'h0);
      apb(1, ADDR_SENSE_CTRL, {30'h0, SENSE_LOW});
      waitc(2);
      chk(wakeRequest, 32'h1);
      u_eivp_far_side.setPins(2'h3, pc);
      waitc(3);
      @(posedge clk_sys) ioClk <= 1'b1;
      waitc(6);
      chk(irqRequest[0], 32'h0);
      // Second dedicated pin on its own sense field, falling edge
      apb(1, ADDR_SENSE_CTRL, {28'h0, SENSE_FALL, SENSE_LOW});
      apb(1, ADDR_EXT_ENABLE, 32'h00000002);
      u_eivp_far_side.setPins(2'h1, pc);
      waitc(6);
      chk(irqRequest[1:0], 32'h2);
      ackPulse();
      chk(irqRequest[1:0], 32'h0);
      u_eivp_far_side.setPins(2'h3, pc);
      waitc(6);
      chk(irqRequest[1:0], 32'h0);
      conclude();
   end
endmodule
